// ==== shared/ctg_timer_regs.vh ====
// Register map, field positions, reset values and timing constants of the
// cascaded gated timer. Assumes a 32-bit AXI4-Lite register bus.
`ifndef CTG_TIMER_REGS_VH
`define CTG_TIMER_REGS_VH

// ============================================================
// Register byte offsets
`define CTG_OFF_LO_CTL      8'h00
`define CTG_OFF_HI_CTL      8'h04
`define CTG_OFF_LO_CNT      8'h08
`define CTG_OFF_HI_CNT      8'h0c
`define CTG_OFF_LO_PER      8'h10
`define CTG_OFF_HI_PER      8'h14
`define CTG_OFF_IRQ_STAT    8'h18
`define CTG_OFF_IRQ_MASK    8'h1c

// ============================================================
// Control register fields
`define CTG_RUN_BIT         15
`define CTG_GATE_BIT        6
`define CTG_PS_HI           5
`define CTG_PS_LO           4
`define CTG_MODE32_BIT      3
`define CTG_CS_BIT          1
`define CTG_CTL_MASK        16'h807a

// ============================================================
// Interrupt status and mask field
`define CTG_MATCH_BIT       7

// ============================================================
// Reset values
`define CTG_RST_CTL         16'h0000
`define CTG_RST_CNT         16'h0000
`define CTG_RST_PER         16'hffff

// ============================================================
// Prescale terminal counts (ratio minus one)
`define CTG_PS_DIV1         8'h00
`define CTG_PS_DIV8         8'h07
`define CTG_PS_DIV64        8'h3f
`define CTG_PS_DIV256       8'hff

// ============================================================
// Bus answers
`define CTG_RESP_OKAY       2'b00
`define CTG_RESP_SLVERR     2'b10

`endif

// ==== verification/ctg_gate_partner.sv ====
// Far-side model: drives the gate pin and consumes trigger pulses.
// Assumes the bench asks for gate levels through gate_req.
`timescale 1ns/1ps
`default_nettype none
module ctg_gate_partner (
    input  wire logic core_clk,
    input  wire logic gate_req,
    input  wire logic adc_trigger,
    output var logic  gate_input_pin,
    output var int    trig_cnt
);
    // Pin moves off the clock grid, as a real asynchronous source would
    initial gate_input_pin = 1'b0;
    always @(gate_req) gate_input_pin <= #37 gate_req;
    initial trig_cnt = 0;
    always @(posedge core_clk) if (adc_trigger === 1'b1) trig_cnt <= trig_cnt + 1;
endmodule // ctg_gate_partner
`default_nettype wire

// ==== verification/ctg_timer_bench.sv ====
// Self-checking bench for the cascaded gated timer.
// Assumes the register map header and a bound port checker.
`timescale 1ns/1ps
`default_nettype none
`include "ctg_timer_regs.vh"
module ctg_timer_bench;
    logic        core_clk, rst_b, clk_en, cpu_sleep, gate_req, gate_input_pin;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, irq, adc_trigger;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, v, v1;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    int          miscompares, n_tests, seed, trig_cnt, i, p;

    ctg_timer i_dut (
        .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .cpu_sleep(cpu_sleep),
        .gate_input_pin(gate_input_pin), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .irq(irq), .adc_trigger(adc_trigger)
    );
    ctg_gate_partner i_gate (
        .core_clk(core_clk), .gate_req(gate_req), .adc_trigger(adc_trigger),
        .gate_input_pin(gate_input_pin), .trig_cnt(trig_cnt)
    );

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // ============================================================
    // Checks and bus tasks
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wrap_up;
        if (miscompares == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic hang;
        chk("wait_limit", 1, 0);
        wrap_up();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (i = 0; i < 64 && s_axi_bvalid !== 1'b1; i++) begin
            @(posedge core_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (i == 64) hang();
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int k;
        @(posedge core_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (k = 0; k < 64 && s_axi_rvalid !== 1'b1; k++) begin
            @(posedge core_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (k == 64) hang();
    endtask
    task automatic wait_trig(output int n);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (adc_trigger !== 1'b1 && n < 3000);
        if (n == 3000) hang();
    endtask
    // Ratios 1, 8, 64, 256 are shifts of 0, 3, 6, 8
    function automatic int gap(input int sel, input int per);
        return (per + 1) << (3 * sel - (sel == 3));
    endfunction
    task automatic msr(input logic [15:0] lc, input logic [15:0] hc, input int e);
        int n, t0;
        wr(`CTG_OFF_LO_CTL, 0);
        wr(`CTG_OFF_HI_CTL, 0);
        wr(`CTG_OFF_LO_CNT, 0);
        wr(`CTG_OFF_HI_CNT, 0);
        wr(`CTG_OFF_LO_PER, lc[3] ? 32'(p) : 32'hffff);
        wr(`CTG_OFF_HI_PER, lc[3] ? 32'h0 : 32'(p));
        wr(`CTG_OFF_HI_CTL, {16'h0, hc});
        wr(`CTG_OFF_LO_CTL, {16'h0, lc});
        wait_trig(n);
        t0 = trig_cnt;
        wait_trig(n);
        chk("trigger_gap", e, n);
        chk("trigger_seen", t0 + 1, trig_cnt);
    endtask
    // ============================================================
    // Main sequence
    initial begin
        seed = 24723;
        {rst_b, cpu_sleep, gate_req, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'h3;
        clk_en = 1'b1;
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        for (p = 0; p < 9; p++) begin
            rd(8'(4 * p), v, rsp);
            chk("reset_value", (p == 4 || p == 5) ? 32'hffff : 32'h0, v);
            chk("resp", p == 8 ? `CTG_RESP_SLVERR : `CTG_RESP_OKAY, rsp);
        end
        wr(8'h20, 32'hffff);
        chk("wr_resp", `CTG_RESP_SLVERR, rsp);
        wr(`CTG_OFF_IRQ_MASK, 32'h80);
        chk("wr_resp", `CTG_RESP_OKAY, rsp);
        p = 2 + {$random(seed)} % 8;
        msr(16'h8008, 16'h0030, gap(0, p));
        wr(`CTG_OFF_LO_CTL, 0);
        rd(`CTG_OFF_IRQ_STAT, v, rsp);
        chk("flag", 32'h80, v);
        chk("irq", 1, irq);
        wr(`CTG_OFF_IRQ_STAT, 32'h80);
        rd(`CTG_OFF_IRQ_STAT, v, rsp);
        chk("flag_clear", 0, v);
        chk("irq_low", 0, irq);
        for (int s = 0; s < 4; s++) begin
            p = 2 + {$random(seed)} % 8;
            msr(16'h8008 | 16'(s << 4), 16'h0030, gap(s, p));
        end
        // A count write in mid-prescale must restart the prescaler from zero
        p = 2 + {$random(seed)} % 8;
        msr(16'h8018, 16'h0000, gap(1, p));
        wr(`CTG_OFF_LO_CNT, 0);
        wait_trig(i);
        chk("prescale_clear", gap(1, p), i);
        p = 2 + {$random(seed)} % 8;
        msr(16'h0000, 16'h8000, gap(0, p));
        wr(`CTG_OFF_LO_CNT, {$random(seed)} | 32'h100);
        wr(`CTG_OFF_LO_CTL, 32'h8008);
        cpu_sleep <= 1'b1;
        rd(`CTG_OFF_LO_CNT, v, rsp);
        wr(`CTG_OFF_LO_CTL, 32'h8038);
        rd(`CTG_OFF_LO_CNT, v1, rsp);
        chk("sleep_count", v, v1);
        cpu_sleep <= 1'b0;
        wr(`CTG_OFF_LO_CTL, 32'h8008);
        rd(`CTG_OFF_LO_CNT, v1, rsp);
        chk("wake_count", 1, v1 != v);
        // Frozen cycles add nothing: two back-to-back reads are four counts apart
        wr(`CTG_OFF_HI_CNT, 0);
        rd(`CTG_OFF_LO_CNT, v, rsp);
        clk_en <= 1'b0;
        repeat (50) @(posedge core_clk);
        clk_en <= 1'b1;
        rd(`CTG_OFF_LO_CNT, v1, rsp);
        chk("freeze_count", 32'h4, (v1 - v) & 32'hffff);
        // High control gate bit must be ignored in gated mode
        wr(`CTG_OFF_HI_CTL, 32'h0040);
        for (int g = 0; g < 2; g++) begin
            wr(`CTG_OFF_LO_CTL, g ? 32'h8048 : 32'h0048);
            wr(`CTG_OFF_LO_CNT, 0);
            wr(`CTG_OFF_HI_CNT, 0);
            wr(`CTG_OFF_IRQ_STAT, 32'h80);
            gate_req <= 1'b1;
            repeat (40) @(posedge core_clk);
            gate_req <= 1'b0;
            repeat (8) @(posedge core_clk);
            rd(`CTG_OFF_LO_CNT, v, rsp);
            repeat (20) @(posedge core_clk);
            rd(`CTG_OFF_LO_CNT, v1, rsp);
            chk("gate_hold", v, v1);
            chk("gate_count", g, v > 36 && v < 44);
            rd(`CTG_OFF_IRQ_STAT, v, rsp);
            if (g) chk("gate_flag", 32'h80, v);
        end
        wrap_up();
    end
endmodule // ctg_timer_bench

bind ctg_timer ctg_timer_checker i_chk (
    .core_clk(core_clk), .rst_b(rst_b), .cpu_sleep(cpu_sleep),
    .gate_input_pin(gate_input_pin),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .irq(irq), .adc_trigger(adc_trigger)
);
`default_nettype wire

// ==== verification/ctg_timer_checker.sv ====
// Port checker for the cascaded gated timer.
// Assumes the bus and the gate pin stay idle whenever clk_en is low.
`timescale 1ns/1ps
`default_nettype none
module ctg_timer_checker (
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic        cpu_sleep,
    input wire logic        gate_input_pin,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        irq,
    input wire logic        adc_trigger
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // ============================================================
    // Bus answers
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("write not answered");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    // ============================================================
    // Timer events
    trig_sleep_a: assert property (
        cpu_sleep |=> !adc_trigger) else $error("trigger while asleep");
    irq_keep_a: assert property (
        $fell(irq) |-> $past(s_axi_wready, 2)) else $error("irq dropped by itself");
    irq_cause_a: assert property (
        $rose(irq) |-> $past(adc_trigger) || $past(s_axi_wready, 2)
        || (!$past(gate_input_pin, 4) && $past(gate_input_pin, 5)))
        else $error("irq without cause");
endmodule // ctg_timer_checker
`default_nettype wire

// ==== verilog/ctg_timer.v ====
// Cascaded 32-bit gated timer with AXI4-Lite register slave.
// Assumes one clock (core_clk, instruction-cycle rate), async active-low reset,
// a same-domain sleep level from the CPU, and an asynchronous gate pin.
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "ctg_timer_regs.vh"

module ctg_timer #(
    parameter ADDR_W = 8
) (
    input  wire              core_clk,
    input  wire              rst_b,
    input  wire              clk_en,
    input  wire              cpu_sleep,
    input  wire              gate_input_pin,
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    output reg               irq,
    output reg               adc_trigger
);

// ============================================================
// Helpers
function hit;
    input [ADDR_W-1:0] addr;
    input [7:0]        off;
    begin
        hit = (addr[7:2] == off[7:2]);
    end
endfunction

function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0]  strb;
    begin
        merge16[7:0]  = strb[0] ? data[7:0]  : old[7:0];
        merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
    end
endfunction

function [7:0] ps_term;
    input [1:0] sel;
    begin
        case (sel)
            2'b00:   ps_term = `CTG_PS_DIV1;
            2'b01:   ps_term = `CTG_PS_DIV8;
            2'b10:   ps_term = `CTG_PS_DIV64;
            default: ps_term = `CTG_PS_DIV256;
        endcase
    end
endfunction

// ============================================================
// Registers
reg [15:0] low_timer_control_q;
reg [15:0] high_timer_control_q;
reg [15:0] low_count_word_q;
reg [15:0] high_count_word_q;
reg [15:0] low_period_word_q;
reg [15:0] high_period_word_q;
reg        period_match_flag_q;
reg        period_match_irq_enable_q;
reg        gate_s1_q;
reg        gate_s2_q;
reg        gate_s3_q;

// ============================================================
// Bus write and read strobes
wire wr_fire = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
wire rd_fire = s_axi_arvalid & s_axi_arready;

wire wr_lo_ctl = wr_fire & hit(s_axi_awaddr, `CTG_OFF_LO_CTL);
wire wr_hi_ctl = wr_fire & hit(s_axi_awaddr, `CTG_OFF_HI_CTL);
wire wr_lo_cnt = wr_fire & hit(s_axi_awaddr, `CTG_OFF_LO_CNT);
wire wr_hi_cnt = wr_fire & hit(s_axi_awaddr, `CTG_OFF_HI_CNT);
wire wr_lo_per = wr_fire & hit(s_axi_awaddr, `CTG_OFF_LO_PER);
wire wr_hi_per = wr_fire & hit(s_axi_awaddr, `CTG_OFF_HI_PER);
wire wr_stat   = wr_fire & hit(s_axi_awaddr, `CTG_OFF_IRQ_STAT);
wire wr_mask   = wr_fire & hit(s_axi_awaddr, `CTG_OFF_IRQ_MASK);
wire wr_known  = wr_lo_ctl | wr_hi_ctl | wr_lo_cnt | wr_hi_cnt |
                 wr_lo_per | wr_hi_per | wr_stat | wr_mask;

// ============================================================
// Timer control decode
wire mode32  = low_timer_control_q[`CTG_MODE32_BIT];
wire run_lo  = low_timer_control_q[`CTG_RUN_BIT];
wire run_hi  = high_timer_control_q[`CTG_RUN_BIT];
wire cs_lo   = low_timer_control_q[`CTG_CS_BIT];
wire gate_en = low_timer_control_q[`CTG_GATE_BIT];
wire awake   = ~cpu_sleep;

wire gate_rise = gate_s2_q & ~gate_s3_q;
wire gate_fall = ~gate_s2_q & gate_s3_q;

// Gating only with internal clock and the timer running
wire gated_mode = run_lo & ~cs_lo & gate_en;
wire src_lo = awake & run_lo &
              (cs_lo ? gate_rise : (~gate_en | gate_s2_q));
// High word only counts on its own in 16-bit mode, internal clock only
wire src_hi = awake & run_hi & ~mode32;

wire cnt_wr = wr_lo_cnt | wr_hi_cnt;
wire ctl_wr = wr_lo_ctl | wr_hi_ctl;

wire [1:0] src    = {src_hi, src_lo};
wire [1:0] run    = {run_hi, run_lo};
wire [3:0] ps_sel = {high_timer_control_q[`CTG_PS_HI:`CTG_PS_LO],
                     low_timer_control_q[`CTG_PS_HI:`CTG_PS_LO]};
wire [1:0] tick;

// ============================================================
// Prescalers, one per timer
genvar gi;
generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_pre
        reg  [7:0] pre_q;
        wire [7:0] term = ps_term(ps_sel[2*gi+1:2*gi]);
        // A stopped prescaler has no clock, so writes cannot clear it
        wire       clr  = (cnt_wr | ctl_wr) & run[gi];
        assign tick[gi] = src[gi] & (pre_q == term);
        always @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
                pre_q <= 8'h00;
            end else if (clk_en) begin
                if (clr) begin
                    pre_q <= 8'h00;
                end else if (tick[gi]) begin
                    pre_q <= 8'h00;
                end else if (src[gi]) begin
                    pre_q <= pre_q + 8'h01;
                end
            end
        end
    end
endgenerate

// ============================================================
// Count next state
reg [31:0] cnt_d;
reg        match_32;
reg        match_hi;
reg        match_lo;

wire [31:0] cnt32 = {high_count_word_q, low_count_word_q};
wire [31:0] per32 = {high_period_word_q, low_period_word_q};

always @* begin
    cnt_d    = cnt32;
    match_32 = 1'b0;
    match_hi = 1'b0;
    match_lo = 1'b0;
    if (mode32) begin
        if (tick[0]) begin
            if (cnt32 == per32) begin
                cnt_d    = 32'h0000_0000;
                match_32 = 1'b1;
            end else begin
                cnt_d = cnt32 + 32'h0000_0001;
            end
        end
    end else begin
        if (tick[0]) begin
            if (low_count_word_q == low_period_word_q) begin
                cnt_d[15:0] = 16'h0000;
                match_lo    = 1'b1;
            end else begin
                cnt_d[15:0] = low_count_word_q + 16'h0001;
            end
        end
        if (tick[1]) begin
            if (high_count_word_q == high_period_word_q) begin
                cnt_d[31:16] = 16'h0000;
                match_hi     = 1'b1;
            end else begin
                cnt_d[31:16] = high_count_word_q + 16'h0001;
            end
        end
    end
    // Software count writes win over a same-cycle increment
    if (wr_lo_cnt) begin
        cnt_d[15:0] = merge16(low_count_word_q, s_axi_wdata, s_axi_wstrb);
    end
    if (wr_hi_cnt) begin
        cnt_d[31:16] = merge16(high_count_word_q, s_axi_wdata, s_axi_wstrb);
    end
end

wire fall_evt  = mode32 & gated_mode & awake & gate_fall;
wire match_evt = match_32 | match_hi;

// ============================================================
// Timer, gate and interrupt state
always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        low_timer_control_q       <= `CTG_RST_CTL;
        high_timer_control_q      <= `CTG_RST_CTL;
        low_count_word_q          <= `CTG_RST_CNT;
        high_count_word_q         <= `CTG_RST_CNT;
        low_period_word_q         <= `CTG_RST_PER;
        high_period_word_q        <= `CTG_RST_PER;
        period_match_flag_q       <= 1'b0;
        period_match_irq_enable_q <= 1'b0;
        gate_s1_q                 <= 1'b0;
        gate_s2_q                 <= 1'b0;
        gate_s3_q                 <= 1'b0;
        irq                       <= 1'b0;
        adc_trigger               <= 1'b0;
    end else if (clk_en) begin
        gate_s1_q <= gate_input_pin;
        gate_s2_q <= gate_s1_q;
        gate_s3_q <= gate_s2_q;
        // Control writes do not touch the count
        if (wr_lo_ctl) begin
            low_timer_control_q <= merge16(low_timer_control_q, s_axi_wdata,
                                           s_axi_wstrb) & `CTG_CTL_MASK;
        end
        if (wr_hi_ctl) begin
            high_timer_control_q <= merge16(high_timer_control_q, s_axi_wdata,
                                            s_axi_wstrb) & `CTG_CTL_MASK;
        end
        if (wr_lo_per) begin
            low_period_word_q <= merge16(low_period_word_q, s_axi_wdata, s_axi_wstrb);
        end
        if (wr_hi_per) begin
            high_period_word_q <= merge16(high_period_word_q, s_axi_wdata, s_axi_wstrb);
        end
        low_count_word_q  <= cnt_d[15:0];
        high_count_word_q <= cnt_d[31:16];
        // Set wins over a same-cycle write-one clear
        if (match_evt | fall_evt) begin
            period_match_flag_q <= 1'b1;
        end else if (wr_stat & s_axi_wstrb[0] & s_axi_wdata[`CTG_MATCH_BIT]) begin
            period_match_flag_q <= 1'b0;
        end
        if (wr_mask & s_axi_wstrb[0]) begin
            period_match_irq_enable_q <= s_axi_wdata[`CTG_MATCH_BIT];
        end
        irq         <= period_match_flag_q & period_match_irq_enable_q;
        adc_trigger <= match_evt;
    end
end

// ============================================================
// Read mux
reg [31:0] rd_d;
reg        rd_ok;

always @* begin
    rd_d  = 32'h0000_0000;
    rd_ok = 1'b1;
    if (hit(s_axi_araddr, `CTG_OFF_LO_CTL)) begin
        rd_d[15:0] = low_timer_control_q;
    end else if (hit(s_axi_araddr, `CTG_OFF_HI_CTL)) begin
        rd_d[15:0] = high_timer_control_q;
    end else if (hit(s_axi_araddr, `CTG_OFF_LO_CNT)) begin
        rd_d[15:0] = low_count_word_q;
    end else if (hit(s_axi_araddr, `CTG_OFF_HI_CNT)) begin
        rd_d[15:0] = high_count_word_q;
    end else if (hit(s_axi_araddr, `CTG_OFF_LO_PER)) begin
        rd_d[15:0] = low_period_word_q;
    end else if (hit(s_axi_araddr, `CTG_OFF_HI_PER)) begin
        rd_d[15:0] = high_period_word_q;
    end else if (hit(s_axi_araddr, `CTG_OFF_IRQ_STAT)) begin
        rd_d[`CTG_MATCH_BIT] = period_match_flag_q;
    end else if (hit(s_axi_araddr, `CTG_OFF_IRQ_MASK)) begin
        rd_d[`CTG_MATCH_BIT] = period_match_irq_enable_q;
    end else begin
        rd_ok = 1'b0;
    end
end

// ============================================================
// AXI4-Lite handshakes
// Address and data are taken together; this costs a cycle but needs no holding regs
always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= `CTG_RESP_OKAY;
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h0000_0000;
        s_axi_rresp   <= `CTG_RESP_OKAY;
    end else if (clk_en) begin
        s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
        s_axi_wready  <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
        if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? `CTG_RESP_OKAY : `CTG_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
        s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
        if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_d;
            s_axi_rresp  <= rd_ok ? `CTG_RESP_OKAY : `CTG_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule // ctg_timer
`default_nettype wire
